// File: rtl/uhf_link_timing_config.sv
// Functional notes
// (RULE1) tx bits 5:4 pick data-one length
// (RULE2) tx bits 2:0 pick Tari, reserved refused
// (RULE3) rx bits 7:4 pick link frequency
// (RULE4) rx bit 3 picks long preamble
// (RULE5) host: short preamble only with Miller 4/8
// (RULE6) rx bits 2:0 pick decoding, reserved refused
// (RULE7) 12-bit calibration value times 0.1 us
// (RULE8) host keeps calibration within air protocol range
// (RULE9) high bit 7 sets oscillator low-supply adaptation
// (RULE10) high bits 6/5 set indicator extra gain
// (RULE11) auto-acknowledge waits value times 3.2 us
// (RULE12) reply timeout after transmission, raises interrupt
// (RULE13) value 255 gives extended 26.2 ms timeout
// (RULE14) detected preamble suppresses no-response interrupt
// (RULE15) host uses extended timeout before writes
// (RULE16) auto-acknowledge mode field, code 11 reserved
// (RULE17) defaults while enable pin is low
// (RULE18) reserved bits read zero, ignored
// (RULE19) steps from clock, changes apply next transmission; the code applies trims and timer values at once
`timescale 1ns/10ps
`include "uhf_link_timing_consts.svh"
`default_nettype none

module uhf_link_timing_config #(
  parameter int TIMEOUT_STEP_CYCLES = `STEP_TIMEOUT_CYCLES,
  parameter int EXT_TIMEOUT_STEPS   = `EXT_TIMEOUT_STEPS
) (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       enable_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // engine events
  input  wire logic       tx_start_i,
  input  wire logic       tx_end_i,
  input  wire logic       preamble_detected_i,
  input  wire logic       ack_reply_i,
  input  wire logic       cal_start_i,
  // symbol and link configuration
  output logic      [1:0] data_one_length_sel_o,
  output logic      [2:0] tari_sel_o,
  output logic      [3:0] link_frequency_sel_o,
  output logic            long_preamble_o,
  output logic      [2:0] rx_coding_o,
  output logic      [1:0] automatic_acknowledge_mode_o,
  // analog trims
  output logic            lo_low_supply_adapt_o,
  output logic            reflected_indicator_gain_double_o,
  output logic            reflected_indicator_gain_one_half_o,
  // timers and interrupt
  output logic            cal_active_o,
  output logic            reply_wait_o,
  output logic            next_command_o,
  output logic            irq_o
);

  // ========================================================================
  // storage
  localparam int TO_W = 11;
  logic                 cfg_rst;
  logic [7:0]           prot_q;
  logic [7:0]           tx_q;
  logic [7:0]           rx_q;
  logic [7:0]           cal_hi_q;
  logic [7:0]           cal_lo_q;
  logic [7:0]           ack_delay_q;
  logic [7:0]           reply_timeout_value;
  logic [`IRQ_BITS-1:0] status_q;
  logic [`IRQ_BITS-1:0] irq_en_q;
  logic [`IRQ_BITS-1:0] status_set;
  logic [`IRQ_BITS-1:0] status_clr;
  logic [11:0]          cal_value;
  logic [TO_W-1:0]      timeout_load;
  logic                 cal_tick;
  logic                 ack_tick;
  logic                 to_tick;
  logic                 ack_start;
  logic                 to_start;
  logic                 to_busy;
  logic                 to_done;

  // ========================================================================
  // legality checks for coded fields
  function automatic logic tari_ok(input logic [2:0] c);
    unique case (uhf_link_timing_pkg::tari_code_t'(c))
      uhf_link_timing_pkg::TARI_6US25,
      uhf_link_timing_pkg::TARI_12US5,
      uhf_link_timing_pkg::TARI_25US: tari_ok = 1'b1;
      default:                        tari_ok = 1'b0;
    endcase
  endfunction : tari_ok

  function automatic logic coding_ok(input logic [2:0] c);
    coding_ok = (c <= 3'(uhf_link_timing_pkg::COD_M8));
  endfunction : coding_ok

  function automatic logic lf_ok(input logic [3:0] c);
    unique case (uhf_link_timing_pkg::link_freq_t'(c))
      uhf_link_timing_pkg::LF_40K,  uhf_link_timing_pkg::LF_160K,
      uhf_link_timing_pkg::LF_250K, uhf_link_timing_pkg::LF_320K,
      uhf_link_timing_pkg::LF_640K: lf_ok = 1'b1;
      default:                      lf_ok = 1'b0;
    endcase
  endfunction : lf_ok

  // ========================================================================
  // power-up defaults also hold while the enable pin is low
  assign cfg_rst = sys_rst_i | ~enable_i; // [RULE17]

  // ========================================================================
  // register writes; a reserved code keeps the old field so the engine never sees it
  always_ff @(posedge clock_i)
  begin
    if (cfg_rst) // [RULE17]
    begin
      prot_q              <= `RST_PROTOCOL_SEL;
      tx_q                <= `RST_TX_SYMBOL_OPT;
      rx_q                <= `RST_RX_LINK_OPT;
      cal_hi_q            <= `RST_CAL_TIME_HIGH;
      cal_lo_q            <= `RST_CAL_TIME_LOW;
      ack_delay_q         <= `RST_AUTO_ACK_DELAY;
      reply_timeout_value <= `RST_REPLY_TIMEOUT;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        `ADDR_PROTOCOL_SEL:
          if (wdata_i[`POS_AUTO_ACK+:2] != 2'h3) // [RULE16]
            prot_q <= wdata_i & `MASK_PROTOCOL_SEL; // [RULE18]
        `ADDR_TX_SYMBOL_OPT:
        begin
          tx_q[`POS_DATA_ONE+:2] <= wdata_i[`POS_DATA_ONE+:2]; // [RULE1]
          if (tari_ok(wdata_i[2:0]))
            tx_q[2:0] <= wdata_i[2:0]; // [RULE2]
        end
        `ADDR_RX_LINK_OPT:
        begin
          rx_q[`POS_LONG_PREAMBLE] <= wdata_i[`POS_LONG_PREAMBLE]; // [RULE4]
          if (lf_ok(wdata_i[`POS_LINK_FREQ+:4]))
            rx_q[`POS_LINK_FREQ+:4] <= wdata_i[`POS_LINK_FREQ+:4]; // [RULE3]
          if (coding_ok(wdata_i[2:0]))
            rx_q[2:0] <= wdata_i[2:0]; // [RULE6]
        end
        `ADDR_CAL_TIME_HIGH:  cal_hi_q <= wdata_i & `MASK_CAL_TIME_HIGH; // [RULE18]
        `ADDR_CAL_TIME_LOW:   cal_lo_q <= wdata_i;
        `ADDR_AUTO_ACK_DELAY: ack_delay_q <= wdata_i;
        `ADDR_REPLY_TIMEOUT:  reply_timeout_value <= wdata_i;
        default:              ;
      endcase
    end
  end

  // ========================================================================
  // interrupt enable, write-only clear
  always_ff @(posedge clock_i)
  begin
    if (cfg_rst)
      irq_en_q <= '0;
    else if (wr_i && addr_i == `ADDR_IRQ_ENABLE)
      irq_en_q <= wdata_i[`IRQ_BITS-1:0];
  end

  assign status_clr = (wr_i && addr_i == `ADDR_IRQ_CLEAR) ? wdata_i[`IRQ_BITS-1:0] : '0;

  // sticky status; a new event in the clear cycle survives
  always_ff @(posedge clock_i)
  begin
    if (cfg_rst)
      status_q <= '0;
    else
      status_q <= (status_q & ~status_clr) | status_set;
  end

  // level interrupt from enabled status
  always_ff @(posedge clock_i)
  begin
    if (cfg_rst)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_q & irq_en_q);
  end

  // ========================================================================
  // read data stands in the cycle after each cycle with rd_i high, zero otherwise
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || !rd_i)
      rdata_o <= 8'h00;
    else
    begin
      unique case (addr_i)
        `ADDR_PROTOCOL_SEL:   rdata_o <= prot_q;
        `ADDR_TX_SYMBOL_OPT:  rdata_o <= tx_q; // [RULE18]
        `ADDR_RX_LINK_OPT:    rdata_o <= rx_q;
        `ADDR_CAL_TIME_HIGH:  rdata_o <= cal_hi_q;
        `ADDR_CAL_TIME_LOW:   rdata_o <= cal_lo_q;
        `ADDR_AUTO_ACK_DELAY: rdata_o <= ack_delay_q;
        `ADDR_REPLY_TIMEOUT:  rdata_o <= reply_timeout_value;
        `ADDR_IRQ_STATUS:     rdata_o <= 8'(status_q);
        `ADDR_IRQ_ENABLE:     rdata_o <= 8'(irq_en_q);
        default:              rdata_o <= 8'h00;
      endcase
    end
  end

  // ========================================================================
  // symbol and link settings latched at transmission start, so a write
  // in mid-frame never disturbs the frame on air
  always_ff @(posedge clock_i)
  begin
    if (cfg_rst)
    begin
      data_one_length_sel_o        <= 2'(`RST_TX_SYMBOL_OPT >> `POS_DATA_ONE);
      tari_sel_o                   <= 3'(`RST_TX_SYMBOL_OPT);
      link_frequency_sel_o         <= 4'(`RST_RX_LINK_OPT >> `POS_LINK_FREQ);
      long_preamble_o              <= 1'(`RST_RX_LINK_OPT >> `POS_LONG_PREAMBLE);
      rx_coding_o                  <= 3'(`RST_RX_LINK_OPT);
      automatic_acknowledge_mode_o <= 2'(`RST_PROTOCOL_SEL >> `POS_AUTO_ACK);
    end
    else if (tx_start_i) // [RULE19]
    begin
      data_one_length_sel_o        <= tx_q[`POS_DATA_ONE+:2]; // [RULE1]
      tari_sel_o                   <= tx_q[2:0]; // [RULE2]
      link_frequency_sel_o         <= rx_q[`POS_LINK_FREQ+:4]; // [RULE3]
      long_preamble_o              <= rx_q[`POS_LONG_PREAMBLE]; // [RULE4]
      rx_coding_o                  <= rx_q[2:0]; // [RULE6]
      automatic_acknowledge_mode_o <= prot_q[`POS_AUTO_ACK+:2]; // [RULE16]
    end
  end

  // trims act directly on the analog side
  assign lo_low_supply_adapt_o               = cal_hi_q[`POS_LO_ADAPT]; // [RULE9]
  assign reflected_indicator_gain_double_o   = cal_hi_q[`POS_GAIN_DOUBLE]; // [RULE10]
  assign reflected_indicator_gain_one_half_o = cal_hi_q[`POS_GAIN_ONE_HALF]; // [RULE10]

  // ========================================================================
  // calibration interval, 0.1 us steps
  assign cal_value = {cal_hi_q[3:0], cal_lo_q}; // [RULE7]

  step_divider #(.CYCLES(`STEP_CAL_CYCLES)) u_cal_div ( // [RULE19]
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (cal_start_i),
    .tick_o    (cal_tick)
  );

  interval_timer #(.W(12)) u_cal_tmr ( // [RULE7]
    .clock_i   (clock_i),
    .sys_rst_i (cfg_rst),
    .tick_i    (cal_tick),
    .start_i   (cal_start_i),
    .cancel_i  (1'b0),
    .load_i    (cal_value),
    .busy_o    (cal_active_o),
    .done_o    ()
  );

  // ========================================================================
  // auto-acknowledge wait, 3.2 us steps, only in an active mode
  assign ack_start = ack_reply_i && (prot_q[`POS_AUTO_ACK+:2] != 2'(uhf_link_timing_pkg::ACK_NONE)); // [RULE16]

  step_divider #(.CYCLES(`STEP_ACK_CYCLES)) u_ack_div (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (ack_start),
    .tick_o    (ack_tick)
  );

  interval_timer #(.W(8)) u_ack_tmr ( // [RULE11]
    .clock_i   (clock_i),
    .sys_rst_i (cfg_rst),
    .tick_i    (ack_tick),
    .start_i   (ack_start),
    .cancel_i  (1'b0),
    .load_i    (ack_delay_q),
    .busy_o    (),
    .done_o    (next_command_o)
  );

  // ========================================================================
  // reply timeout; zero disables it, 255 selects the long form
  assign timeout_load = (reply_timeout_value == `TIMEOUT_EXTENDED) ? TO_W'(EXT_TIMEOUT_STEPS) // [RULE13]
                                                                   : TO_W'(reply_timeout_value); // [RULE12]
  assign to_start     = tx_end_i && (reply_timeout_value != 8'h00); // [RULE12]

  step_divider #(.CYCLES(TIMEOUT_STEP_CYCLES)) u_to_div (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (to_start),
    .tick_o    (to_tick)
  );

  // a detected preamble stops the count before it can expire
  interval_timer #(.W(TO_W)) u_to_tmr ( // [RULE14]
    .clock_i   (clock_i),
    .sys_rst_i (cfg_rst),
    .tick_i    (to_tick),
    .start_i   (to_start),
    .cancel_i  (preamble_detected_i),
    .load_i    (timeout_load),
    .busy_o    (to_busy),
    .done_o    (to_done)
  );

  assign reply_wait_o = to_busy;

  // event sources of the status register
  always_comb
  begin
    status_set                    = '0;
    status_set[`IRQ_NO_RESPONSE]  = to_done; // [RULE12]
    status_set[`IRQ_REPLY_SEEN]   = preamble_detected_i && to_busy; // [RULE14]
    status_set[`IRQ_NEXT_COMMAND] = next_command_o;
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (cfg_rst);

  AST_TX_RESERVED_ZERO: assert property ( // [RULE18]
    rd_i && addr_i == `ADDR_TX_SYMBOL_OPT |=> rdata_o[7:6] == 2'h0 && !rdata_o[3])
    else $error("reserved transmit option bits read nonzero");
  AST_TARI_LEGAL: assert property (tari_ok(tx_q[2:0])) // [RULE2]
    else $error("reserved tari code stored");
  AST_LF_LEGAL: assert property (lf_ok(rx_q[7:4])) // [RULE3]
    else $error("reserved link frequency stored");
  AST_CODING_LEGAL: assert property (coding_ok(rx_q[2:0])) // [RULE6]
    else $error("reserved receive coding stored");
  AST_SHADOW_AT_START: assert property ( // [RULE19]
    tx_start_i |=> data_one_length_sel_o == $past(tx_q[5:4]) && long_preamble_o == $past(rx_q[3]))
    else $error("settings not taken at transmission start");
  AST_SHADOW_HOLD: assert property (!tx_start_i |=> $stable(rx_coding_o)) // [RULE19]
    else $error("receive coding changed outside a transmission start");
  AST_ACK_ZERO_WAIT: assert property ( // [RULE11]
    ack_start && ack_delay_q == 8'h00 |=> next_command_o)
    else $error("zero auto-acknowledge wait not immediate");
  AST_ACK_NO_MODE: assert property ( // [RULE16]
    prot_q[5:4] == 2'h0 && ack_reply_i && !u_ack_tmr.busy_o |=> !next_command_o)
    else $error("next command without auto-acknowledge mode");
  AST_CAL_RUNS: assert property ( // [RULE7]
    cal_start_i && cal_value > 12'h001 |=> cal_active_o [*4])
    else $error("calibration interval ended too soon");
  AST_TIMEOUT_SUPPRESSED: assert property ( // [RULE14]
    preamble_detected_i && !to_done |=> !to_busy ##1 !status_q[`IRQ_NO_RESPONSE] || $past(status_q[0], 2))
    else $error("no-response raised after preamble");
  AST_TIMEOUT_FLAG: assert property ( // [RULE12]
    to_done |=> status_q[`IRQ_NO_RESPONSE] ##1 (irq_o || !$past(irq_en_q[0])))
    else $error("expired timeout did not raise its flag");
  AST_EXT_LOAD: assert property ( // [RULE13]
    to_start && !preamble_detected_i && reply_timeout_value == 8'hff |=> u_to_tmr.cnt_q == TO_W'(EXT_TIMEOUT_STEPS))
    else $error("extended timeout not loaded");

  COV_TIMEOUT_EXPIRES: cover property (to_done);
  COV_PREAMBLE_IN_TIME: cover property (to_busy && preamble_detected_i);
  COV_NEXT_COMMAND: cover property (next_command_o && prot_q[5:4] == 2'h2);
  COV_SET_AND_CLEAR: cover property (|(status_set & status_clr));

endmodule : uhf_link_timing_config

`default_nettype wire

// File: rtl/uhf_link_timing_consts.svh
`ifndef UHF_LINK_TIMING_CONSTS_SVH
`define UHF_LINK_TIMING_CONSTS_SVH

// ==========================================================================
// register offsets
`define ADDR_PROTOCOL_SEL      8'h01
`define ADDR_TX_SYMBOL_OPT     8'h02
`define ADDR_RX_LINK_OPT       8'h03
`define ADDR_CAL_TIME_HIGH     8'h04
`define ADDR_CAL_TIME_LOW      8'h05
`define ADDR_AUTO_ACK_DELAY    8'h06
`define ADDR_REPLY_TIMEOUT     8'h07
`define ADDR_IRQ_STATUS        8'h10
`define ADDR_IRQ_CLEAR         8'h11
`define ADDR_IRQ_ENABLE        8'h12

// ==========================================================================
// reset values
`define RST_PROTOCOL_SEL       8'h00
`define RST_TX_SYMBOL_OPT      8'h32
`define RST_RX_LINK_OPT        8'hca
`define RST_CAL_TIME_HIGH      8'h02
`define RST_CAL_TIME_LOW       8'h9b
`define RST_AUTO_ACK_DELAY     8'h04
`define RST_REPLY_TIMEOUT      8'h0f

// ==========================================================================
// writable bit masks, everything else reads zero
`define MASK_PROTOCOL_SEL      8'h30
`define MASK_TX_SYMBOL_OPT     8'h37
`define MASK_CAL_TIME_HIGH     8'hef
`define IRQ_BITS               3

// ==========================================================================
// field positions
`define POS_AUTO_ACK           4
`define POS_DATA_ONE           4
`define POS_LINK_FREQ          4
`define POS_LONG_PREAMBLE      3
`define POS_LO_ADAPT           7
`define POS_GAIN_DOUBLE        6
`define POS_GAIN_ONE_HALF      5
`define IRQ_NO_RESPONSE        0
`define IRQ_REPLY_SEEN         1
`define IRQ_NEXT_COMMAND       2
`define TIMEOUT_EXTENDED       8'hff

// ==========================================================================
// timing, times in ns, counts derived from the clock period
`define CLK_PERIOD_NS          20
`define STEP_CAL_NS            100
`define STEP_ACK_NS            3200
`define STEP_TIMEOUT_NS        25600
`define EXT_TIMEOUT_NS         26200000
`define CYC_UP(t)              (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_CAL_CYCLES        `CYC_UP(`STEP_CAL_NS)
`define STEP_ACK_CYCLES        `CYC_UP(`STEP_ACK_NS)
`define STEP_TIMEOUT_CYCLES    `CYC_UP(`STEP_TIMEOUT_NS)
`define EXT_TIMEOUT_STEPS      ((`EXT_TIMEOUT_NS + `STEP_TIMEOUT_NS - 1) / `STEP_TIMEOUT_NS)

`endif

// File: rtl/uhf_link_timing_pkg.sv
`default_nettype none

package uhf_link_timing_pkg;

  // ========================================================================
  // field encodings
  typedef enum logic [2:0] {TARI_6US25 = 3'h0, TARI_12US5 = 3'h1, TARI_25US = 3'h2} tari_code_t;
  typedef enum logic [2:0] {COD_FM0 = 3'h0, COD_M2 = 3'h1, COD_M4 = 3'h2, COD_M8 = 3'h3} rx_coding_t;
  typedef enum logic [3:0] {
    LF_40K = 4'h0, LF_160K = 4'h6, LF_250K = 4'h9, LF_320K = 4'hc, LF_640K = 4'hf
  } link_freq_t;
  typedef enum logic [1:0] {
    ACK_NONE = 2'h0, ACK_ONLY = 2'h1, ACK_HANDLE = 2'h2
  } auto_ack_mode_t;

endpackage : uhf_link_timing_pkg

`default_nettype wire

// File: rtl/step_divider.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// restartable step tick generator
module step_divider #(
  parameter int CYCLES = 5
) (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  // control
  input  wire logic restart_i,
  output logic      tick_o
);

  logic [15:0] cnt_q;

  // restart aligns the step grid to the start of a timed interval
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || restart_i || tick_o)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  assign tick_o = (cnt_q == 16'(CYCLES - 1));

endmodule : step_divider

`default_nettype wire

// File: rtl/interval_timer.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// counts a loaded number of step ticks
module interval_timer #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  // control
  input  wire logic         tick_i,
  input  wire logic         start_i,
  input  wire logic         cancel_i,
  input  wire logic [W-1:0] load_i,
  output logic              busy_o,
  output logic              done_o
);

  logic [W-1:0] cnt_q;

  // cancel beats start; a zero load finishes at once
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || cancel_i)
    begin
      cnt_q  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        cnt_q  <= load_i;
        busy_o <= (load_i != '0);
        done_o <= (load_i == '0);
      end
      else if (busy_o && tick_i)
      begin
        cnt_q <= cnt_q - W'(1);
        if (cnt_q == W'(1))
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule : interval_timer

`default_nettype wire

// File: test/host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// host controller on the register port
module host_model (
  // clock
  input  wire logic       clock_i,
  // register port
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // idle bus at time zero
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // one-cycle write, reserved bits as the caller gives them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    addr_o <= ~a; // released lines lose the old value
    wdata_o <= ~d;
    #1;
  endtask : wr

  // one-cycle read, data only stands in the next cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask : rd
endmodule : host_model
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic       clock_i, sys_rst_i, enable_i, wr, rd;
  logic [7:0] addr, wdata, rdata, v, tx, rx, pr, ntx, nrx, npr;
  logic [4:0] ev;
  logic [1:0] one_sel, ack_mode;
  logic [2:0] tari_sel, coding;
  logic [3:0] lf_sel;
  logic       long_pre, lo_adapt, gain_dbl, gain_half, cal_act, rwait, next_cmd, irq;
  logic [14:0] cfg;
  logic [2:0] w;
  logic [3:0] lf_tab [5] = '{4'h0, 4'h6, 4'h9, 4'hc, 4'hf};
  logic [7:0] dflt [6] = '{8'h32, 8'hca, 8'h02, 8'h9b, 8'h04, 8'h0f};
  int         err_count = 0;
  int         checks_done = 0;

  assign cfg = {one_sel, tari_sel, lf_sel, long_pre, coding, ack_mode};
  assign w = {next_cmd, ~cal_act, ~rwait};

  // ========================================================================
  // design and host
  uhf_link_timing_config #(.TIMEOUT_STEP_CYCLES(4), .EXT_TIMEOUT_STEPS(8)) uhf_link_timing_config_inst (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .enable_i(enable_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .tx_start_i(ev[0]), .tx_end_i(ev[1]), .preamble_detected_i(ev[2]), .ack_reply_i(ev[3]), .cal_start_i(ev[4]),
    .data_one_length_sel_o(one_sel), .tari_sel_o(tari_sel), .link_frequency_sel_o(lf_sel),
    .long_preamble_o(long_pre), .rx_coding_o(coding), .automatic_acknowledge_mode_o(ack_mode),
    .lo_low_supply_adapt_o(lo_adapt), .reflected_indicator_gain_double_o(gain_dbl),
    .reflected_indicator_gain_one_half_o(gain_half), .cal_active_o(cal_act), .reply_wait_o(rwait),
    .next_command_o(next_cmd), .irq_o(irq));
  host_model host_model_inst (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  // ========================================================================
  // helpers
  function automatic logic [14:0] cfg_exp(input logic [7:0] t, input logic [7:0] r, input logic [7:0] p);
    return {t[5:4], t[2:0], r, p[5:4]};
  endfunction : cfg_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic pulse(input int k);
    @(posedge clock_i);
    ev[k] <= 1'b1;
    @(posedge clock_i);
    ev[k] <= 1'b0;
    #1;
  endtask : pulse

  // start a timer and count cycles until its end shows; step divider may slip a cycle
  task automatic run(input int k, input int j, input int n_exp);
    int n;
    n = 0;
    pulse(k);
    while (!w[j] && n < 3000)
    begin
      @(posedge clock_i);
      #1 n++;
    end
    chk(32'(n >= n_exp - 1 && n <= n_exp + 2), 32'h1);
  endtask : run

  // status, level interrupt, then clear
  task automatic stat(input logic [7:0] e, input logic ie);
    repeat (3) @(posedge clock_i);
    #1 chk(irq, ie);
    host_model_inst.rd(8'h10, v);
    chk(v, e);
    host_model_inst.wr(8'h11, 8'h07);
    @(posedge clock_i);
    #1 chk(irq, 1'b0);
  endtask : stat

  // register table, outputs, interrupt enable and one unmapped place at their defaults
  task automatic defaults();
    chk(cfg, cfg_exp(8'h32, 8'hca, 8'h00));
    chk({lo_adapt, gain_dbl, gain_half, irq}, 4'h0);
    foreach (dflt[i])
    begin
      host_model_inst.rd(8'(i + 2), v);
      chk(v, dflt[i]);
    end
    host_model_inst.rd(8'h20, v);
    chk(v, 8'h00);
    host_model_inst.rd(8'h12, v);
    chk(v, 8'h00);
  endtask : defaults

  // ========================================================================
  // clock and watchdog
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial
  begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    conclude();
  end

  // ========================================================================
  // main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    enable_i = 1'b1;
    ev = 5'h00;
    tx = 8'h32;
    rx = 8'hca;
    pr = 8'h00;
    void'($urandom(51521));
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1 defaults();
    // every legal code, new values only after the next transmission start
    for (int i = 0; i < 8; i++)
    begin
      ntx = {2'h0, 2'($urandom), 1'b0, 3'(i % 3)};
      nrx = {lf_tab[i % 5], 1'b0, 3'(i % 4)};
      nrx[3] = (i % 4 < 2) | 1'($urandom); // short preamble only with Miller 4/8
      npr = {2'h0, 2'(i % 3), 4'h0};
      host_model_inst.wr(8'h02, ntx);
      host_model_inst.wr(8'h03, nrx);
      host_model_inst.wr(8'h01, npr);
      chk(cfg, cfg_exp(tx, rx, pr));
      pulse(0);
      tx = ntx;
      rx = nrx;
      pr = npr;
      chk(cfg, cfg_exp(tx, rx, pr));
      host_model_inst.rd(8'h03, v);
      chk(v, rx);
    end
    // reserved codes keep the old field, reserved bits read zero
    host_model_inst.wr(8'h02, 8'hff);
    host_model_inst.wr(8'h03, 8'h5f);
    host_model_inst.wr(8'h01, 8'h30);
    pulse(0);
    tx = {4'h3, 1'b0, tx[2:0]};
    rx = {rx[7:4], 1'b1, rx[2:0]};
    chk(cfg, cfg_exp(tx, rx, pr));
    host_model_inst.rd(8'h02, v);
    chk(v, tx);
    // analog trims and the 12-bit calibration time, 258 steps in the air range
    host_model_inst.wr(8'h04, 8'hff);
    host_model_inst.rd(8'h04, v);
    chk(v, 8'hef);
    chk({lo_adapt, gain_dbl, gain_half}, 3'h7);
    host_model_inst.wr(8'h04, 8'h41);
    host_model_inst.wr(8'h05, 8'h02);
    chk({lo_adapt, gain_dbl, gain_half}, 3'h2);
    run(4, 1, 258 * 5);
    // reply timeout, enabled then masked, then cancelled by a preamble
    host_model_inst.wr(8'h12, 8'h07);
    host_model_inst.wr(8'h07, 8'h02);
    run(1, 0, 8);
    stat(8'h01, 1'b1);
    host_model_inst.wr(8'h12, 8'h00);
    run(1, 0, 8);
    stat(8'h01, 1'b0);
    host_model_inst.wr(8'h12, 8'h07);
    pulse(1);
    pulse(2);
    chk(rwait, 1'b0);
    stat(8'h02, 1'b1);
    host_model_inst.wr(8'h07, 8'hff);
    run(1, 0, 32);
    stat(8'h01, 1'b1);
    // acknowledge wait of zero steps, then of three steps
    host_model_inst.wr(8'h01, 8'h10);
    pulse(0);
    host_model_inst.wr(8'h06, 8'h00);
    run(3, 2, 0);
    host_model_inst.wr(8'h06, 8'h03);
    run(3, 2, 480);
    stat(8'h04, 1'b1);
    // enable pin low restores everything
    @(posedge clock_i);
    enable_i <= 1'b0;
    @(posedge clock_i);
    enable_i <= 1'b1;
    #1 defaults();
    // mode none after reset: a zero wait would show at once if it started
    host_model_inst.wr(8'h06, 8'h00);
    pulse(3);
    chk(next_cmd, 1'b0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
